// >>> logic/psp_cfg.svh
/*
 * Constants of the parallel slave port controller: APB offsets,
 * field positions, reset values and interrupt bit positions.
 * Assumes it is included by the package, whose macros the design modules then use.
 */
// Notes on behaviour
// - Input-buffer-full, bit 7, set on master write
// - Output-buffer-full, bit 6, until master reads
// - Input overflow, bit 5, sticky until software clears
// - Bit 4 selects slave port or general I/O
// - Port-E direction bits: 1 input, 0 output
// - Bit 3 always reads as zero
// - Both full flags zero after power-on reset
`ifndef PSP_CFG_SVH
`define PSP_CFG_SVH

// APB byte offsets
`define PSP_OFS_STAT 8'h00
`define PSP_OFS_IN 8'h04
`define PSP_OFS_OUT 8'h08
`define PSP_OFS_ISTS 8'h0C
`define PSP_OFS_IMSK 8'h10
`define PSP_OFS_GOUT 8'h14
`define PSP_OFS_GIN 8'h18

// Field positions in the status and direction register
`define PSP_BIT_IN_FULL 7
`define PSP_BIT_OUT_FULL 6
`define PSP_BIT_IN_OVF 5
`define PSP_BIT_MODE 4

// Interrupt status and mask bit positions
`define PSP_IRQ_RX 0
`define PSP_IRQ_TX 1
`define PSP_IRQ_OV 2

// Reset values
`define PSP_RST_DIR 3'h7
`define PSP_RST_DDIR 8'hFF

// Port-E pins used as strobes in slave mode
`define PSP_PIN_RD 0
`define PSP_PIN_WR 1
`define PSP_PIN_CS 2

`endif

// >>> logic/psp_pkg.sv
/*
 * Types of the parallel slave port controller.
 * Assumes psp_cfg.svh is on the include path.
 */
package psp_pkg;
    `include "psp_cfg.svh"

    // Register-side state of the controller
    typedef struct packed {
        logic in_full;      // Input word pending
        logic out_full;     // Output word not yet taken
        logic in_ovf;       // Overflow seen
        logic mode;         // Slave port mode
        logic [2:0] dir;    // Port-E directions
        logic [2:0] ists;   // Sticky interrupt status
        logic [2:0] imsk;   // Interrupt mask
        logic [7:0] glat;   // Data-port output latch
        logic [7:0] ddir;   // Data-port directions
        logic [2:0] elat;   // Port-E output latch
        logic rd_act;       // Read strobe active last cycle
        logic wr_act;       // Write strobe active last cycle
        logic [31:0] rdata; // APB read data
    } psp_state_s;

    // One byte of storage
    typedef struct packed {
        logic [7:0] data;
    } psp_byte_s;
endpackage : psp_pkg

// >>> logic/psp_byte_reg.sv
/*
 * One byte of buffer storage with a load strobe.
 * Assumes a single clock and an asynchronous active-low reset.
 */
`timescale 1ns/10ps
module psp_byte_reg
    import psp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [7:0] din,
    output logic [7:0] dout
);
    psp_byte_s st_q;   // Stored byte
    psp_byte_s st_d;   // Next stored byte

    // Take the new byte on a load strobe
    always_comb begin
        st_d = st_q;
        if (load) begin
            st_d.data = din;
        end
    end

    // Register the byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.data;
endmodule : psp_byte_reg

// >>> logic/psp_ctrl.sv
/*
 * Parallel slave port controller: an external master writes bytes
 * into an input buffer and reads bytes from an output buffer through
 * strobes on the port-E pins; software reaches status, data, GPIO
 * and interrupt registers over APB.
 * Assumes all pins are synchronous to pclk and that the bench
 * resolves the three-signal pins into wires.
 */
`timescale 1ns/10ps
module psp_ctrl
    import psp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic [7:0] data_oe_n,
    input wire logic [2:0] pe_in,
    output logic [2:0] pe_out,
    output logic [2:0] pe_oe_n,
    output logic irq
);
    psp_state_s st_q;     // Registered state
    psp_state_s st_d;     // Next state
    logic [7:0] in_byte;  // Input buffer contents
    logic [7:0] out_byte; // Output buffer contents
    logic acc;            // APB access phase
    logic setup;          // APB setup phase
    logic cs_act;         // Master selects the port
    logic rd_now;         // Master read strobe active
    logic wr_now;         // Master write strobe active
    logic wr_start;       // First cycle of a master write
    logic rd_end;         // Master read just finished
    logic cpu_rd_in;      // Software reads the input buffer
    logic cpu_wr_out;     // Software writes the output buffer
    logic cpu_wr_stat;    // Software writes the status register
    logic cpu_rd_ists;    // Software reads interrupt status
    logic [2:0] ev;       // Interrupt events this cycle

    // Offset decode used by both access decode and error answer
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == `PSP_OFS_STAT) || (a == `PSP_OFS_IN) ||
                  (a == `PSP_OFS_OUT) || (a == `PSP_OFS_ISTS) ||
                  (a == `PSP_OFS_IMSK) || (a == `PSP_OFS_GOUT) ||
                  (a == `PSP_OFS_GIN);
    endfunction : addr_ok

    // Status and direction register image
    function automatic logic [7:0] stat_img(input psp_state_s s);
        stat_img = {s.in_full, s.out_full, s.in_ovf, s.mode, 1'b0,
                    s.dir};
    endfunction : stat_img

    // Input buffer, loaded by the master write strobe
    psp_byte_reg u_in_buf (
        .pclk(pclk),
        .presetn(presetn),
        .load(wr_start),
        .din(data_in),
        .dout(in_byte)
    );

    // Output buffer, loaded by software
    psp_byte_reg u_out_buf (
        .pclk(pclk),
        .presetn(presetn),
        .load(cpu_wr_out),
        .din(pwdata[7:0]),
        .dout(out_byte)
    );

    // APB phase and access decode
    always_comb begin
        setup = psel && !penable;
        acc = psel && penable && addr_ok(paddr);
        cpu_rd_in = acc && !pwrite && (paddr == `PSP_OFS_IN);
        cpu_wr_out = acc && pwrite && (paddr == `PSP_OFS_OUT);
        cpu_wr_stat = acc && pwrite && (paddr == `PSP_OFS_STAT);
        cpu_rd_ists = acc && !pwrite && (paddr == `PSP_OFS_ISTS);
    end

    // Master strobes, active low on the port-E pins, slave mode only
    always_comb begin
        cs_act = st_q.mode && !pe_in[`PSP_PIN_CS];
        rd_now = cs_act && !pe_in[`PSP_PIN_RD];
        wr_now = cs_act && !pe_in[`PSP_PIN_WR];
        wr_start = wr_now && !st_q.wr_act;
        rd_end = st_q.rd_act && !rd_now;
        ev = '0;
        ev[`PSP_IRQ_RX] = wr_start;
        ev[`PSP_IRQ_TX] = rd_end && st_q.out_full;
        ev[`PSP_IRQ_OV] = wr_start && st_q.in_full && !cpu_rd_in;
    end

    // Next-state logic for flags, control and read data
    always_comb begin
        st_d = st_q;
        st_d.rd_act = rd_now;
        st_d.wr_act = wr_now;
        // Input flag: the CPU read clears, a new word wins
        if (cpu_rd_in) begin
            st_d.in_full = 1'b0;
        end
        if (wr_start) begin
            st_d.in_full = 1'b1;
        end
        // Output flag: the master read clears, a new write wins
        if (rd_end) begin
            st_d.out_full = 1'b0;
        end
        if (cpu_wr_out) begin
            st_d.out_full = 1'b1;
        end
        // Control fields and software clear of the overflow flag
        if (cpu_wr_stat) begin
            st_d.mode = pwdata[`PSP_BIT_MODE];
            st_d.dir = pwdata[2:0];
            if (!pwdata[`PSP_BIT_IN_OVF]) begin
                st_d.in_ovf = 1'b0;
            end
        end
        // Overflow set wins over the software clear
        if (ev[`PSP_IRQ_OV]) begin
            st_d.in_ovf = 1'b1;
        end
        // Other writable registers
        if (acc && pwrite && (paddr == `PSP_OFS_IMSK)) begin
            st_d.imsk = pwdata[2:0];
        end
        if (acc && pwrite && (paddr == `PSP_OFS_GOUT)) begin
            st_d.glat = pwdata[7:0];
            st_d.elat = pwdata[10:8];
            st_d.ddir = pwdata[23:16];
        end
        // Sticky events: a read clears, an event in that cycle stays
        if (cpu_rd_ists) begin
            st_d.ists = ev;
        end else begin
            st_d.ists = st_q.ists | ev;
        end
        // Read data is prepared in the setup phase
        if (setup) begin
            st_d.rdata = '0;
            unique case (paddr)
                `PSP_OFS_STAT: begin
                    st_d.rdata[7:0] = stat_img(st_q);
                end
                `PSP_OFS_IN: begin
                    st_d.rdata[7:0] = in_byte;
                end
                `PSP_OFS_OUT: begin
                    st_d.rdata[7:0] = out_byte;
                end
                `PSP_OFS_ISTS: begin
                    st_d.rdata[2:0] = st_q.ists | ev;
                end
                `PSP_OFS_IMSK: begin
                    st_d.rdata[2:0] = st_q.imsk;
                end
                `PSP_OFS_GOUT: begin
                    st_d.rdata = {8'h00, st_q.ddir, 5'h00, st_q.elat,
                                  st_q.glat};
                end
                `PSP_OFS_GIN: begin
                    st_d.rdata = {21'h000000, pe_in, data_in};
                end
                default: begin
                    st_d.rdata = '0;
                end
            endcase
        end
    end

    // State register; both full flags clear at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            st_q.dir <= `PSP_RST_DIR;
            st_q.ddir <= `PSP_RST_DDIR;
        end else begin
            st_q <= st_d;
        end
    end

    // APB answer: no wait states, error on unmapped offsets
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok(paddr);
    assign prdata = st_q.rdata;
    assign irq = |(st_q.ists & st_q.imsk);

    // Data bus: output buffer during a master read in slave mode
    always_comb begin
        if (st_q.mode) begin
            data_out = out_byte;
            data_oe_n = rd_now ? 8'h00 : 8'hFF;
        end else begin
            data_out = st_q.glat;
            data_oe_n = st_q.ddir;
        end
    end

    // Port-E pins: strobe inputs in slave mode, else by direction
    always_comb begin
        pe_out = st_q.elat;
        if (st_q.mode) begin
            pe_oe_n = 3'h7;
        end else begin
            pe_oe_n = st_q.dir;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // One complete master read cycle
    sequence seq_rd_cycle;
        rd_now ##1 !rd_now;
    endsequence

    // Start of a master write
    sequence seq_wr_begin;
        !st_q.wr_act && wr_now;
    endsequence

    a_in_full_set: assert property (seq_wr_begin |=> st_q.in_full)
        else $error("input flag not set after master write");

    a_in_full_clear: assert property (
        cpu_rd_in && !wr_start |=> !st_q.in_full)
        else $error("input flag not cleared by cpu read");

    a_out_full_set: assert property (cpu_wr_out |=> st_q.out_full)
        else $error("output flag not set after write");

    a_out_full_clear: assert property (
        seq_rd_cycle ##0 !cpu_wr_out |=> !st_q.out_full)
        else $error("output flag not cleared by master read");

    a_in_ovf_set: assert property (
        seq_wr_begin ##0 (st_q.in_full && !cpu_rd_in)
        |=> st_q.in_ovf)
        else $error("overflow not flagged");

    a_in_ovf_sticky: assert property (
        st_q.in_ovf && !cpu_wr_stat |=> st_q.in_ovf)
        else $error("overflow flag lost without software clear");

    a_gpio_data_dir: assert property (
        !st_q.mode |-> data_oe_n == st_q.ddir && !wr_start)
        else $error("data bus not general I/O in I/O mode");

    a_dir_pins: assert property (
        !st_q.mode |-> pe_oe_n == st_q.dir)
        else $error("port-E direction mismatch");

    a_bit3_reads0: assert property (
        setup && paddr == `PSP_OFS_STAT && !pwrite
        ##1 psel && penable |-> prdata[3] == 1'b0)
        else $error("unimplemented bit reads nonzero");

    a_rd_drives: assert property (
        rd_now |-> data_oe_n == 8'h00 && data_out == out_byte)
        else $error("output buffer not driven during read");
endmodule : psp_ctrl

// >>> tb/psp_host_model.sv
/*
 * Behavioural external bus master that writes and reads the slave
 * port through the port-E strobes and the shared data bus.
 * Assumes strobes synchronous to pclk and a bench calling its tasks.
 */
`timescale 1ns/10ps
module psp_host_model (
    input wire logic pclk,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe_n,
    input wire logic [2:0] pe_out,
    input wire logic [2:0] pe_oe_n,
    output logic [7:0] data_in,
    output logic [2:0] pe_in
);
    logic [2:0] stb_n_q = 3'h7; // [2] select, [1] write, [0] read
    logic [7:0] drv_q = 8'h00; // Last byte put on the bus
    logic drv_en_q = 1'b0; // Master drives the bus
    logic [7:0] mst; // Master side of the bus

    // A released bus shows the inverse of the last byte
    assign mst = drv_en_q ? drv_q : ~drv_q;
    // Resolve the shared pins from the port's enables alone
    assign data_in = (data_out & ~data_oe_n) | (mst & data_oe_n);
    assign pe_in = (pe_out & ~pe_oe_n) | (stb_n_q & pe_oe_n);

    // Write one byte, then keep the strobes idle for a cycle
    task wr(input logic [7:0] b);
        @(posedge pclk);
        stb_n_q <= 3'h1;
        drv_q <= b;
        drv_en_q <= 1'b1;
        repeat (2) @(posedge pclk);
        stb_n_q <= 3'h7;
        drv_en_q <= 1'b0;
        @(posedge pclk);
    endtask : wr

    // Read one byte while the port drives the bus
    task rd(output logic [7:0] b);
        @(posedge pclk);
        stb_n_q <= 3'h2;
        repeat (2) @(posedge pclk);
        b = data_in;
        stb_n_q <= 3'h7;
        repeat (2) @(posedge pclk);
    endtask : rd
endmodule : psp_host_model

// >>> tb/parallel_slave_port_ctrl_tb_top.sv
/*
 * Self-checking bench of the slave port controller: APB master,
 * external master model and a queue-based read checker.
 * Assumes psp_ctrl and psp_host_model are compiled before it.
 */
`timescale 1ns/10ps
module parallel_slave_port_ctrl_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
    logic [7:0] data_in, data_out, data_oe_n;
    logic [2:0] pe_in, pe_out, pe_oe_n;
    int mismatches = 0; // Failed comparisons
    int total_checks = 0; // All comparisons
    integer seed; // Random seed
    logic [32:0] exp_q[$]; // Expected {pslverr, prdata} per read
    logic [7:0] d, b1, b2, b3, got; // Random bytes and the byte read back from the bus

    // 100 MHz clock
    initial begin
        forever #5 pclk = ~pclk;
    end

    psp_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .pe_in(pe_in), .pe_out(pe_out),
        .pe_oe_n(pe_oe_n), .irq(irq));

    psp_host_model m (.pclk(pclk), .data_out(data_out),
        .data_oe_n(data_oe_n), .pe_out(pe_out), .pe_oe_n(pe_oe_n),
        .data_in(data_in), .pe_in(pe_in));

    // Count and report one comparison
    task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // Print the counts and the verdict, then stop
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // One APB transfer: setup, then access until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) begin
            mismatches++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Read with the expected answer noted first
    task rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Compare each completed read against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk("reg read", exp_q.pop_front(), {pslverr, prdata});
        end
    end

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        end_of_test();
    end

    // Main sequence
    initial begin
        seed = 32'hE9398B34;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 33'h7);
        rd(8'h0C, 33'h0);
        rd(8'h10, 33'h0);
        rd(8'h1C, {1'b1, 32'h0});
        $display("test reset done");
        // I/O mode: directions drive the enables, strobes ignored
        repeat (3) begin
            d = $random(seed);
            apb(1'b1, 8'h00, {29'h0, d[2:0]});
            @(negedge pclk);
            chk("pe dir", {30'h0, d[2:0]}, {30'h0, pe_oe_n});
            m.wr(d);
            rd(8'h00, {30'h0, d[2:0]});
        end
        // General I/O latches drive the pins and read back
        apb(1'b1, 8'h14, {8'h00, 8'h00, 5'h00, d[2:0], d});
        @(negedge pclk);
        chk("data out", {25'h0, d}, {25'h0, data_out});
        chk("pe out", {30'h0, d[2:0]}, {30'h0, pe_out});
        rd(8'h14, {1'b0, 21'h0, d[2:0], d});
        rd(8'h18, {1'b0, 21'h0, d[2:0], d});
        $display("test io mode done");
        // Slave mode with bit 3 written high
        apb(1'b1, 8'h00, 32'h18);
        @(negedge pclk);
        chk("pe slave", 33'h7, {30'h0, pe_oe_n});
        rd(8'h00, 33'h10);
        b1 = $random(seed);
        b2 = $random(seed);
        b3 = $random(seed);
        m.wr(b1);
        @(negedge pclk);
        chk("irq masked", 33'h0, {32'h0, irq});
        rd(8'h00, 33'h90);
        apb(1'b1, 8'h10, 32'h7);
        @(negedge pclk);
        chk("irq raised", 33'h1, {32'h0, irq});
        m.wr(b2);
        rd(8'h00, 33'hB0);
        rd(8'h0C, 33'h5);
        @(negedge pclk);
        chk("irq cleared", 33'h0, {32'h0, irq});
        rd(8'h04, {25'h0, b2});
        rd(8'h00, 33'h30);
        apb(1'b1, 8'h00, 32'h30);
        rd(8'h00, 33'h30);
        apb(1'b1, 8'h00, 32'h10);
        rd(8'h00, 33'h10);
        $display("test input done");
        // Output buffer handed to the external master
        apb(1'b1, 8'h08, {24'h0, b3});
        rd(8'h00, 33'h50);
        m.rd(got);
        chk("bus byte", {25'h0, b3}, {25'h0, got});
        @(negedge pclk);
        chk("irq out", 33'h1, {32'h0, irq});
        rd(8'h00, 33'h10);
        rd(8'h0C, 33'h2);
        $display("test output done");
        end_of_test();
    end
endmodule : parallel_slave_port_ctrl_tb_top
